// ==== rtl/adcsq_pkg.sv ====
// package with register map, field positions and timing constants for the converter control
// Functional notes
// [RQ1] module_on runs converter; else standby or off
// [RQ2] standby_select picks standby versus full off
// [RQ3] stop_in_idle halts conversion while idle
// [RQ4] output_format selects four result word layouts
// [RQ5] trigger source ends sampling, starts conversion
// [RQ6] auto_sample restarts sampling after each conversion
// [RQ7] sample_bit shows sampling; software and hardware drive
// [RQ8] conversion_status busy flag; software clear only
// [RQ9] unimplemented bits read zero, ignore writes
// [RQ10] reference_config selects upper and lower references
// [RQ11] unused reference codes default to supply, ground
// [RQ12] offset_calibration shorts sample inputs together
// [RQ13] scan_enable steps positive input through scan list
// [RQ14] buffer_status shows which half is filling
// [RQ15] buffer_status meaningful only split; writes ignored
// [RQ16] interrupt after samples_per_interrupt plus one conversions
// [RQ17] split_buffer alternates start word 0x0 and 0x8
// [RQ18] alternate_input alternates first and second selection
// [RQ19] software keeps settings fixed while module on
// [RQ20] sixteen ten-bit result words, read formatted
// [RQ21] internal counter samples auto_sample_time converter clocks
package adcsq_pkg;
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
	localparam logic [7:0] ADDR_TIMING = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_BUF_BASE = 8'h40;
	localparam logic [15:0] CTRL_ONE_MASK = 16'hb3e7;
	localparam logic [15:0] CTRL_TWO_MASK = 16'hf43f;
	localparam logic [15:0] TIMING_MASK = 16'h1f3f;
	localparam int ON_BIT = 15;
	localparam int IDLE_BIT = 13;
	localparam int STBY_BIT = 12;
	localparam int FORM_LO = 8;
	localparam int TRIG_LO = 5;
	localparam int AUTO_SAMPLE_BIT = 2;
	localparam int SAMPLE_BIT_BIT = 1;
	localparam int CONVERSION_STATUS_BIT = 0;
	localparam int VREF_LO = 13;
	localparam int CAL_BIT = 12;
	localparam int SCAN_BIT = 10;
	localparam int BUFFER_STATUS_BIT = 7;
	localparam int SMPI_LO = 2;
	localparam int SPLIT_BIT = 1;
	localparam int ALT_BIT = 0;
	localparam int SAMC_LO = 8;
	localparam int ADCS_LO = 0;
	localparam logic [2:0] TRIG_SOFT = 3'h0;
	localparam logic [2:0] TRIG_PIN = 3'h1;
	localparam logic [2:0] TRIG_TIMER = 3'h2;
	localparam logic [2:0] TRIG_PWM = 3'h3;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	localparam logic [3:0] HALF_SIZE = 4'h8;
	localparam int CONVERSION_STATUS_BITS = 10;
	localparam logic [3:0] CONVERSION_STATUS_TAD = 4'hc;
	typedef enum logic [1:0] {
		adcsq_pwr_off_t_dummy = 2'h0
	} adcsq_unused_t;
	typedef enum {
		ADCSQ_IDLE,
		ADCSQ_SAMPLE,
		ADCSQ_CONVERT
	} adcsq_state_t;
	typedef enum logic [1:0] {
		ADCSQ_PWR_OFF,
		ADCSQ_PWR_STANDBY,
		ADCSQ_PWR_RUN
	} adcsq_power_t;
	typedef enum logic [2:0] {
		ADCSQ_REF_SUPPLY,
		ADCSQ_REF_EXT_HI,
		ADCSQ_REF_EXT_LO,
		ADCSQ_REF_EXT_BOTH,
		ADCSQ_REF_INTERNAL,
		ADCSQ_REF_SUPPLY_INT_LO
	} adcsq_ref_t;
endpackage

// ==== rtl/adcsq_control.sv ====
// converter sequencing control with axi4-lite register slave
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module adcsq_control (
	input wire logic aclk, // system clock, 250 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic cpu_idle, // core in idle mode, same clock
	input wire logic trig_pin, // external interrupt pin, asynchronous
	input wire logic trig_timer, // timer compare pulse, same clock
	input wire logic trig_pwm, // motor pwm interval pulse, same clock
	input wire logic [9:0] conversion_status_result, // converter core result
	input wire logic conversion_status_done, // converter core finished, one-cycle pulse
	input wire logic [15:0] input_select, // first and second channel selects
	input wire logic [15:0] scan_select, // inputs in the scan list
	output logic [1:0] power_mode, // off, standby, run
	output logic analog_enable, // analog circuits powered
	output logic sample_hold, // 1 sampling, 0 holding
	output logic conversion_status_start, // start conversion, one-cycle pulse
	output logic [2:0] ref_select, // effective reference pair
	output logic inputs_shorted, // offset calibration short
	output logic [3:0] pos_input, // channel 0 positive input
	output logic neg_input, // channel 0 negative input select
	output logic conversion_status_irq // interrupt, one-cycle pulse
);
	logic [15:0] ctrl_one;
	logic [15:0] ctrl_two;
	logic [15:0] timing;
	logic [9:0] result_mem [16];
	logic [3:0] wr_ptr;
	logic [3:0] sample_count;
	logic [6:0] tq_count;
	logic tad_tick;
	logic [4:0] tad_count;
	logic use_second;
	logic [3:0] scan_pos;
	logic pin_meta, pin_sync, pin_last;
	adcsq_pkg::adcsq_state_t state;
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic running, trig_hit, wr_go, sw_write_one;
	logic [15:0] wr_word;
	logic [2:0] trig_src;

	// merge byte lanes of a write into a 16-bit register
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] s, input logic [15:0] mask);
		logic [15:0] m;
		m = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
		return m & mask;
	endfunction

	// present a raw result as a 16-bit word
	function automatic logic [15:0] fmt(input logic [9:0] r, input logic [1:0] f);
		logic [15:0] w;
		w = {6'h00, r};
		case (f)
			2'h0: w = {6'h00, r};
			// seven sign bits, each the inverted result msb
			2'h1: w = {{7{~r[9]}}, r[8:0]};
			2'h2: w = {r, 6'h00};
			default: w = {~r[9], r[8:0], 6'h00};
		endcase
		return w;
	endfunction

	assign running = ctrl_one[adcsq_pkg::ON_BIT] &
		~(ctrl_one[adcsq_pkg::IDLE_BIT] & cpu_idle); // [RQ1] [RQ3]
	assign trig_src = ctrl_one[adcsq_pkg::TRIG_LO +: 3];
	assign wr_go = aw_held & w_held & ~s_axi_bvalid;
	assign sw_write_one = wr_go & (aw_addr == adcsq_pkg::ADDR_CTRL_ONE);
	assign wr_word = merge(ctrl_one, w_data, w_strb, adcsq_pkg::CTRL_ONE_MASK); // [RQ9]

	always_comb begin
		case (trig_src) // [RQ5]
			adcsq_pkg::TRIG_SOFT: trig_hit = sw_write_one & ~wr_word[adcsq_pkg::SAMPLE_BIT_BIT];
			adcsq_pkg::TRIG_PIN: trig_hit = pin_sync & ~pin_last;
			adcsq_pkg::TRIG_TIMER: trig_hit = trig_timer;
			adcsq_pkg::TRIG_PWM: trig_hit = trig_pwm;
			adcsq_pkg::TRIG_AUTO: trig_hit = tad_tick &
				(tad_count >= timing[adcsq_pkg::SAMC_LO +: 5]); // [RQ21]
			default: trig_hit = 1'b0;
		endcase
	end

	// pin crossing: first flop feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_last <= 1'b0;
		end else begin
			pin_meta <= trig_pin;
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	// converter clock divider: period 2*(select+1) system clocks
	// seven bits so the slowest setting, 128 system clocks, still fits
	always_ff @(posedge aclk) begin
		if (!aresetn || !running) begin
			tq_count <= 7'h00;
			tad_tick <= 1'b0;
		end else if (tq_count == ({1'b0, timing[adcsq_pkg::ADCS_LO +: 6]} << 1) + 7'h01) begin
			tq_count <= 7'h00;
			tad_tick <= 1'b1;
		end else begin
			tq_count <= tq_count + 7'h01;
			tad_tick <= 1'b0;
		end
	end

	// sampling and conversion sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= adcsq_pkg::ADCSQ_IDLE;
			tad_count <= 5'h00;
			conversion_status_start <= 1'b0;
		end else begin
			conversion_status_start <= 1'b0;
			case (state)
				adcsq_pkg::ADCSQ_IDLE: begin
					tad_count <= 5'h00;
					if (running && ctrl_one[adcsq_pkg::SAMPLE_BIT_BIT]) begin
						state <= adcsq_pkg::ADCSQ_SAMPLE;
					end
				end
				adcsq_pkg::ADCSQ_SAMPLE: begin
					if (!running) begin
						state <= adcsq_pkg::ADCSQ_IDLE;
					end else if (trig_hit) begin
						state <= adcsq_pkg::ADCSQ_CONVERT; // [RQ5]
						conversion_status_start <= 1'b1;
					end else if (tad_tick && tad_count != 5'h1f) begin
						tad_count <= tad_count + 5'h01;
					end
				end
				adcsq_pkg::ADCSQ_CONVERT: begin
					tad_count <= 5'h00;
					if (!running) begin
						state <= adcsq_pkg::ADCSQ_IDLE;
					end else if (conversion_status_done) begin
						state <= ctrl_one[adcsq_pkg::AUTO_SAMPLE_BIT] ? adcsq_pkg::ADCSQ_SAMPLE
							: adcsq_pkg::ADCSQ_IDLE; // [RQ6]
					end
				end
				default: state <= adcsq_pkg::ADCSQ_IDLE;
			endcase
		end
	end

	// control register one, with sample and busy bits also driven by hardware
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_one <= 16'h0000;
		end else begin
			if (sw_write_one) begin
				ctrl_one <= {wr_word[15:1],
					ctrl_one[adcsq_pkg::CONVERSION_STATUS_BIT] & wr_word[adcsq_pkg::CONVERSION_STATUS_BIT]}; // [RQ8]
			end
			// hardware updates come last so they win over a software write
			if (state == adcsq_pkg::ADCSQ_SAMPLE && trig_hit && running) begin
				ctrl_one[adcsq_pkg::SAMPLE_BIT_BIT] <= 1'b0; // [RQ7]
				ctrl_one[adcsq_pkg::CONVERSION_STATUS_BIT] <= 1'b1; // [RQ8]
			end
			if (state == adcsq_pkg::ADCSQ_CONVERT && conversion_status_done) begin
				ctrl_one[adcsq_pkg::CONVERSION_STATUS_BIT] <= 1'b0; // [RQ8]
				if (ctrl_one[adcsq_pkg::AUTO_SAMPLE_BIT]) begin
					ctrl_one[adcsq_pkg::SAMPLE_BIT_BIT] <= 1'b1; // [RQ6] [RQ7]
				end
			end
		end
	end

	// control register two and timing register; buffer_status is hardware only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_two <= 16'h0000;
			timing <= 16'h0000;
		end else if (wr_go) begin
			if (aw_addr == adcsq_pkg::ADDR_CTRL_TWO) begin
				ctrl_two <= merge(ctrl_two, w_data, w_strb, adcsq_pkg::CTRL_TWO_MASK); // [RQ9] [RQ15]
			end else if (aw_addr == adcsq_pkg::ADDR_TIMING) begin
				timing <= merge(timing, w_data, w_strb, adcsq_pkg::TIMING_MASK);
			end
		end
	end

	// result storage, interrupt counting and buffer half switching
	always_ff @(posedge aclk) begin
		if (!aresetn || !ctrl_one[adcsq_pkg::ON_BIT]) begin
			wr_ptr <= 4'h0;
			sample_count <= 4'h0;
			conversion_status_irq <= 1'b0;
		end else begin
			conversion_status_irq <= 1'b0;
			if (state == adcsq_pkg::ADCSQ_CONVERT && conversion_status_done && running) begin
				result_mem[wr_ptr] <= conversion_status_result; // [RQ20]
				if (sample_count == ctrl_two[adcsq_pkg::SMPI_LO +: 4]) begin
					sample_count <= 4'h0;
					conversion_status_irq <= 1'b1; // [RQ16]
					if (ctrl_two[adcsq_pkg::SPLIT_BIT]) begin
						// [RQ17] next fill starts at the other half
						wr_ptr <= wr_ptr[3] ? 4'h0 : adcsq_pkg::HALF_SIZE;
					end else begin
						wr_ptr <= 4'h0;
					end
				end else begin
					sample_count <= sample_count + 4'h1;
					wr_ptr <= wr_ptr + 4'h1;
				end
			end
		end
	end

	// input selection: alternate and scan advance per completed sample
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			use_second <= 1'b0;
			scan_pos <= 4'h0;
		end else if (!ctrl_one[adcsq_pkg::ON_BIT]) begin
			// park on the lowest listed input so the first sample uses it
			use_second <= 1'b0;
			scan_pos <= next_scan(4'hf, scan_select); // [RQ13]
		end else if (state == adcsq_pkg::ADCSQ_CONVERT && conversion_status_done) begin
			use_second <= ctrl_two[adcsq_pkg::ALT_BIT] & ~use_second; // [RQ18]
			if (ctrl_two[adcsq_pkg::SCAN_BIT] && !use_second) begin
				scan_pos <= next_scan(scan_pos, scan_select); // [RQ13]
			end
		end
	end

	// next input set in the scan list after the current one
	function automatic logic [3:0] next_scan(input logic [3:0] cur, input logic [15:0] list);
		logic [3:0] n;
		n = cur;
		for (int i = 1; i <= 16; i++) begin
			if (list[4'(cur + 4'(i))] && n == cur) begin
				n = 4'(cur + 4'(i));
			end
		end
		return n;
	endfunction

	// outputs to the analog side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_mode <= adcsq_pkg::ADCSQ_PWR_OFF;
			analog_enable <= 1'b0;
			sample_hold <= 1'b0;
			ref_select <= adcsq_pkg::ADCSQ_REF_SUPPLY;
			inputs_shorted <= 1'b0;
			pos_input <= 4'h0;
			neg_input <= 1'b0;
		end else begin
			if (ctrl_one[adcsq_pkg::ON_BIT]) begin
				power_mode <= adcsq_pkg::ADCSQ_PWR_RUN; // [RQ1]
			end else if (ctrl_one[adcsq_pkg::STBY_BIT]) begin
				power_mode <= adcsq_pkg::ADCSQ_PWR_STANDBY; // [RQ2]
			end else begin
				power_mode <= adcsq_pkg::ADCSQ_PWR_OFF; // [RQ2]
			end
			analog_enable <= ctrl_one[adcsq_pkg::ON_BIT];
			sample_hold <= state == adcsq_pkg::ADCSQ_SAMPLE; // [RQ7]
			case (ctrl_two[adcsq_pkg::VREF_LO +: 3]) // [RQ10]
				3'h1: ref_select <= adcsq_pkg::ADCSQ_REF_EXT_HI;
				3'h2: ref_select <= adcsq_pkg::ADCSQ_REF_EXT_LO;
				3'h3: ref_select <= adcsq_pkg::ADCSQ_REF_EXT_BOTH;
				3'h4: ref_select <= adcsq_pkg::ADCSQ_REF_INTERNAL;
				3'h7: ref_select <= adcsq_pkg::ADCSQ_REF_SUPPLY_INT_LO;
				default: ref_select <= adcsq_pkg::ADCSQ_REF_SUPPLY; // [RQ11]
			endcase
			inputs_shorted <= ctrl_two[adcsq_pkg::CAL_BIT]; // [RQ12]
			if (use_second) begin
				pos_input <= input_select[11:8]; // [RQ18]
				neg_input <= input_select[12];
			end else begin
				pos_input <= ctrl_two[adcsq_pkg::SCAN_BIT] ? scan_pos : input_select[3:0]; // [RQ13]
				neg_input <= input_select[4];
			end
		end
	end

	// axi4-lite write: address and data taken in either order
	assign s_axi_awready = ~aw_held;
	assign s_axi_wready = ~w_held;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr == adcsq_pkg::ADDR_CTRL_ONE || aw_addr == adcsq_pkg::ADDR_CTRL_TWO
						|| aw_addr == adcsq_pkg::ADDR_TIMING) begin
					s_axi_bresp <= 2'h0;
				end else begin
					s_axi_bresp <= 2'h2;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi4-lite read: one cycle after the address is taken
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			if (s_axi_araddr[7:2] == adcsq_pkg::ADDR_CTRL_ONE[7:2]) begin
				s_axi_rdata <= {16'h0000, ctrl_one};
			end else if (s_axi_araddr[7:2] == adcsq_pkg::ADDR_CTRL_TWO[7:2]) begin
				s_axi_rdata <= {16'h0000, ctrl_two[15:8], wr_ptr[3], ctrl_two[6:0]}; // [RQ14]
			end else if (s_axi_araddr[7:2] == adcsq_pkg::ADDR_TIMING[7:2]) begin
				s_axi_rdata <= {16'h0000, timing};
			end else if (s_axi_araddr[7:2] == adcsq_pkg::ADDR_STATUS[7:2]) begin
				s_axi_rdata <= {26'h0000000, sample_count, 2'(state)};
			end else if (s_axi_araddr[7:6] == adcsq_pkg::ADDR_BUF_BASE[7:6]) begin
				s_axi_rdata <= {16'h0000,
					fmt(result_mem[s_axi_araddr[5:2]], ctrl_one[adcsq_pkg::FORM_LO +: 2])}; // [RQ4]
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'h2;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== tb/adcsq_props.sv ====
// checker with assertions on the ports of the converter control
`timescale 1ns/1ps
`default_nettype none
module adcsq_props (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, active low
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] power_mode, // power state
	input wire logic analog_enable, // analog powered
	input wire logic sample_hold, // sampling
	input wire logic conversion_status_start, // start pulse
	input wire logic [2:0] ref_select, // reference pair
	input wire logic [3:0] pos_input, // positive input
	input wire logic conversion_status_irq // interrupt pulse
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before ready");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before ready");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while data pending");
	AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_PWR_CODE: assert property (power_mode != 2'h3)
		else $error("power mode code out of range");
	AST_ANALOG: assert property (analog_enable == (power_mode == adcsq_pkg::ADCSQ_PWR_RUN))
		else $error("analog power disagrees with power mode");
	AST_START_RUN: assert property (conversion_status_start |-> power_mode == adcsq_pkg::ADCSQ_PWR_RUN)
		else $error("conversion started while not running");
	AST_START_PULSE: assert property (conversion_status_start |=> !conversion_status_start)
		else $error("start pulse longer than one cycle");
	AST_HOLD_ON_START: assert property (conversion_status_start |-> ##[1:3] !sample_hold)
		else $error("sample stage not holding after start");
	AST_IRQ_PULSE: assert property (conversion_status_irq |=> !conversion_status_irq)
		else $error("interrupt pulse longer than one cycle");
	AST_REF_CODE: assert property (ref_select <= 3'h5)
		else $error("reference select out of range");
	cover property (conversion_status_irq);
	cover property (conversion_status_start && pos_input == 4'h9);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind adcsq_control adcsq_props i_adcsq_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.power_mode, .analog_enable, .sample_hold, .conversion_status_start, .ref_select, .pos_input, .conversion_status_irq);
`default_nettype wire

// ==== tb/adcsq_core_model.sv ====
// behavioural converter core answering start pulses
`timescale 1ns/1ps
`default_nettype none
module adcsq_core_model #(
	parameter int LAT = 6
) (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, active low
	input wire logic conversion_status_start, // start pulse
	output logic conversion_status_done, // done pulse
	output logic [9:0] conversion_status_result // result
);
	int cnt;
	logic [9:0] val;
	always @(posedge aclk) begin
		conversion_status_done <= 1'b0;
		if (!aresetn) begin
			cnt <= 0;
			val <= 10'h201;
			conversion_status_result <= 10'h000;
		end else if (conversion_status_start) begin
			cnt <= LAT;
		end else if (cnt == 1) begin
			conversion_status_done <= 1'b1;
			conversion_status_result <= val;
			val <= val + 10'h001;
			cnt <= 0;
		end else begin
			// result is only valid with done, so scramble it otherwise
			if (cnt > 1)
				cnt <= cnt - 1;
			conversion_status_result <= ~conversion_status_result;
		end
	end
endmodule
`default_nettype wire

// ==== tb/adcsq_control_test.sv ====
// self-checking bench for the converter sequencing control
`timescale 1ns/1ps
`default_nettype none
module adcsq_control_test;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'h0, pos_input;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, power_mode, rs;
	logic cpu_idle = 1'b1, trig_pin = 1'b0, trig_timer = 1'b0, trig_pwm = 1'b0;
	logic [15:0] input_select = 16'h1903, scan_select = 16'h0000;
	logic [9:0] conversion_status_result;
	logic conversion_status_done, analog_enable, sample_hold, conversion_status_start, inputs_shorted, neg_input, conversion_status_irq;
	logic [2:0] ref_select;
	logic [4:0] posq [$];
	int bad_count = 0, checks = 0, cyc = 0, starts = 0, dones = 0, irqs = 0, n, m;
	// address, write data, readback, power mode or {short, reference}
	logic [43:0] rows [11] = '{44'h007ffc33e41, 44'h00800080002, 44'h00000000000,
		44'h04fffff43fd, 44'h04000000000, 44'h04200020001, 44'h04400040002,
		44'h04600060003, 44'h04800080004, 44'h04a000a0000, 44'h04c000c0000};
	logic [15:0] fmt [4] = '{16'h0202, 16'h0002, 16'h8080, 16'h0080};
	always #2 aclk = ~aclk;
	adcsq_control i_adcsq_control (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .cpu_idle, .trig_pin, .trig_timer, .trig_pwm, .conversion_status_result,
		.conversion_status_done, .input_select, .scan_select, .power_mode, .analog_enable, .sample_hold,
		.conversion_status_start, .ref_select, .inputs_shorted, .pos_input, .neg_input, .conversion_status_irq);
	adcsq_core_model #(.LAT(6)) i_adcsq_core_model (.aclk, .aresetn, .conversion_status_start, .conversion_status_done,
		.conversion_status_result);
	task automatic give_verdict;
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic aw, w;
		@(posedge aclk);
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'h3;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (conversion_status_start === 1'b1) begin
			starts++;
			posq.push_back({neg_input, pos_input});
		end
		if (conversion_status_done === 1'b1)
			dones++;
		if (conversion_status_irq === 1'b1)
			irqs++;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h04);
		chk("control two at reset", 32'h0, rv);
		chk("power mode at reset", 32'h0, {30'h0, power_mode});
		foreach (rows[i]) begin
			wr(rows[i][43:36], rows[i][35:20]);
			rd(rows[i][43:36]);
			chk("readback", {16'h0, rows[i][19:4]}, rv);
			if (rows[i][43:36] == 8'h00)
				chk("power mode", {30'h0, rows[i][1:0]}, {30'h0, power_mode});
			else
				chk("ref and short", {28'h0, rows[i][3:0]}, {28'h0, inputs_shorted, ref_select});
		end
		wr(8'h20, 16'hffff);
		chk("unmapped write resp", 32'h2, {30'h0, rs});
		rd(8'h20);
		chk("unmapped read resp", 32'h2, {30'h0, rs});
		chk("unmapped read data", 32'h0, rv);
		wr(8'h08, 16'h0300);
		wr(8'h04, 16'h0007);
		wr(8'h00, 16'ha0e6);
		repeat (60) @(posedge aclk);
		chk("starts while idle", 32'h0, starts);
		cpu_idle <= 1'b0;
		while (irqs < 1) @(posedge aclk);
		rd(8'h04);
		chk("fill half first", 32'h87, rv);
		while (irqs < 2) @(posedge aclk);
		chk("conversions per irq", 32'h4, dones);
		wr(8'h00, 16'h0000);
		rd(8'h04);
		chk("fill half second", 32'h07, rv);
		for (int i = 0; i < 4; i++)
			chk("alternate input", i[0] ? 32'h19 : 32'h03, {27'h0, posq[i]});
		rd(8'h60);
		chk("upper half result", 32'h0203, rv);
		for (int f = 0; f < 4; f++) begin
			wr(8'h00, {6'h00, f[1:0], 8'h00});
			rd(8'h44);
			chk("result format", {16'h0, fmt[f]}, rv);
		end
		// scan list of inputs 2 and 5, set up while the module is off
		scan_select <= 16'h0024;
		wr(8'h04, 16'h0400);
		n = starts;
		wr(8'h00, 16'h80e6);
		while (starts < n + 3) @(posedge aclk);
		wr(8'h00, 16'h0000);
		for (int i = 0; i < 3; i++)
			chk("scan input", i == 1 ? 32'h05 : 32'h02, {27'h0, posq[n + i]});
		// trigger sources are only changed with the module off
		wr(8'h04, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, 16'h0000);
			wr(8'h00, {8'h80, c[2:0], 5'h02});
			n = starts;
			m = dones;
			repeat (4) @(posedge aclk);
			chk("no start before trigger", n, starts);
			if (c == 0)
				wr(8'h00, 16'h8000);
			else if (c == 1)
				trig_pin <= 1'b1;
			else if (c == 2)
				trig_timer <= 1'b1;
			else
				trig_pwm <= 1'b1;
			@(posedge aclk);
			trig_timer <= 1'b0;
			trig_pwm <= 1'b0;
			repeat (3) @(posedge aclk);
			trig_pin <= 1'b0;
			while (dones <= m) @(posedge aclk);
			rd(8'h00);
			chk("status after conversion", {16'h0, 8'h80, c[2:0], 5'h00}, rv);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
